/* spc_pkg.sv */
package spc_pkg;
  // ---------------------------------------------------------------
  // Behaviour select encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] SPC_SEL_HW_SEQ   = 2'h0;
  localparam logic [1:0] SPC_SEL_HW_IMM   = 2'h1;
  localparam logic [1:0] SPC_SEL_SW_KEEP  = 2'h2;
  localparam logic [1:0] SPC_SEL_RESET    = 2'h0;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int SPC_CLK_HZ          = 20000000;
  localparam int SPC_OFF_NORAMP_US10 = 2;     // 0.2 ms in units of 0.1 ms
  localparam int SPC_OFF_RAMP_US10   = 139;   // 13.9 ms in units of 0.1 ms
  localparam int SPC_READY_MAX_US    = 300;
  // Longest times round down
  localparam int SPC_OFF_NORAMP_CYC  = SPC_CLK_HZ / 10000 * SPC_OFF_NORAMP_US10;
  localparam int SPC_OFF_RAMP_CYC    = SPC_CLK_HZ / 10000 * SPC_OFF_RAMP_US10;
  localparam int SPC_READY_CYC       = SPC_CLK_HZ / 1000000 * SPC_READY_MAX_US;
  localparam int SPC_CNT_W           = 20;

  // ---------------------------------------------------------------
  // Carried signals
  // ---------------------------------------------------------------
  typedef struct packed {
    logic amp_enable;     // Class-D switching allowed
    logic analog_on;
    logic digital_on;
    logic ramp_down;      // Volume ramp request
    logic hw_shutdown;
    logic sw_shutdown;
    logic regs_to_default;
    logic i2c_enable;
  } spc_ctrl_t;
endpackage : spc_pkg

/* spc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module spc_sync
(
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic din,
  output var  logic dout
);
  logic meta_q;
  logic sync_q;

  // Pin idles high; reset to that to avoid a false shutdown
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end
    else
    begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule : spc_sync
`default_nettype wire

/* spc_shutdown_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Low pin powers down, behaviour per select
// - Modes 00/01 low: defaults, control port off
// - Mode 00: ramp, stop switching, power down, shutdown
// - Mode 01: immediate hardware shutdown, no sequence
// - Mode 10: sequence then software shutdown, keep registers
// - Mode 10: control port stays usable
// - Select resets to 00
// - Output off after 0.2 or 13.9 ms
// - Ready for commands within 300 us
module spc_shutdown_ctrl
  import spc_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              shutdown_pin_n,
  input  wire logic [1:0]        sel_wr_data,
  input  wire logic              sel_wr_en,
  input  wire logic              ramp_enable,
  input  wire logic              address_select_pin_1,
  input  wire logic              address_select_pin_2,
  output var  logic [1:0]        shutdown_behaviour_select,
  output var  spc_pkg::spc_ctrl_t ctrl,
  output var  logic [1:0]        address_sampled,
  output var  logic              ready
);
  import spc_pkg::*;

  // ---------------------------------------------------------------
  // States
  // ---------------------------------------------------------------
  typedef enum logic [5:0]
  {
    SPC_ACTIVE = 6'h01,
    SPC_RAMP   = 6'h02,
    SPC_PWRDN  = 6'h04,
    SPC_HWSD   = 6'h08,
    SPC_SWSD   = 6'h10,
    SPC_WAKE   = 6'h20
  } spc_state_t;

  spc_state_t             state_q;
  logic                   pin_s;
  logic [SPC_CNT_W-1:0]   cnt_q;
  logic [SPC_CNT_W-1:0]   off_cnt;
  logic                   ramp_latched_q;
  logic [1:0]             sel_q;

  // ---------------------------------------------------------------
  // Pin synchroniser
  // ---------------------------------------------------------------
  spc_sync u_sync
  (
    .clk_sys (clk_sys),
    .rst     (rst),
    .din     (shutdown_pin_n),
    .dout    (pin_s)
  );

  assign off_cnt = ramp_latched_q ? SPC_CNT_W'(SPC_OFF_RAMP_CYC)
                                  : SPC_CNT_W'(SPC_OFF_NORAMP_CYC);

  // ---------------------------------------------------------------
  // Behaviour select
  // ---------------------------------------------------------------
  // Software write ignored while the control port is off
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      sel_q <= SPC_SEL_RESET;
    else if (state_q == SPC_HWSD)
      sel_q <= SPC_SEL_RESET;
    else if (sel_wr_en && ctrl.i2c_enable)
      sel_q <= sel_wr_data;
  end

  assign shutdown_behaviour_select = sel_q;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_q        <= SPC_ACTIVE;
      cnt_q          <= '0;
      ramp_latched_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        SPC_ACTIVE:
        begin
          cnt_q <= '0;
          if (!pin_s)
          begin
            ramp_latched_q <= ramp_enable;
            if (sel_q == SPC_SEL_HW_IMM)
              state_q <= SPC_HWSD;
            else
              state_q <= SPC_RAMP;
          end
        end
        SPC_RAMP:
        begin
          cnt_q <= cnt_q + 1'b1;
          // Turn-off time bounds the whole sequence
          if (cnt_q >= off_cnt - SPC_CNT_W'(2))
          begin
            cnt_q   <= '0;
            state_q <= SPC_PWRDN;
          end
        end
        SPC_PWRDN:
        begin
          if (sel_q == SPC_SEL_SW_KEEP)
            state_q <= SPC_SWSD;
          else
            state_q <= SPC_HWSD;
        end
        SPC_HWSD, SPC_SWSD:
        begin
          cnt_q <= '0;
          if (pin_s)
            state_q <= SPC_WAKE;
        end
        SPC_WAKE:
        begin
          cnt_q <= cnt_q + 1'b1;
          // Early pin fall restarts via active state
          // Sync and output flops use four cycles of the budget
          if (cnt_q >= SPC_CNT_W'(SPC_READY_CYC - 5))
          begin
            cnt_q   <= '0;
            state_q <= SPC_ACTIVE;
          end
        end
        default:
          state_q <= SPC_ACTIVE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Address pins caught on release
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      address_sampled <= 2'h0;
    else if ((state_q == SPC_HWSD || state_q == SPC_SWSD) && pin_s)
      address_sampled <= {address_select_pin_2, address_select_pin_1};
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ctrl  <= '{amp_enable:1'b1, analog_on:1'b1, digital_on:1'b1,
                 ramp_down:1'b0, hw_shutdown:1'b0, sw_shutdown:1'b0,
                 regs_to_default:1'b0, i2c_enable:1'b1};
      ready <= 1'b1;
    end
    else
    begin
      ctrl.ramp_down       <= (state_q == SPC_RAMP) && ramp_latched_q;
      ctrl.amp_enable      <= (state_q == SPC_ACTIVE) ||
                              ((state_q == SPC_RAMP) && ramp_latched_q);
      ctrl.analog_on       <= state_q inside {SPC_ACTIVE, SPC_RAMP};
      ctrl.digital_on      <= state_q inside {SPC_ACTIVE, SPC_RAMP};
      ctrl.hw_shutdown     <= (state_q == SPC_HWSD);
      ctrl.sw_shutdown     <= (state_q == SPC_SWSD);
      ctrl.regs_to_default <= (state_q == SPC_HWSD);
      // Port off from ramp through wake-up in hardware modes
      ctrl.i2c_enable      <= !((state_q inside {SPC_RAMP, SPC_PWRDN,
                                SPC_HWSD, SPC_WAKE}) &&
                                (sel_q != SPC_SEL_SW_KEEP));
      ready                <= (state_q == SPC_ACTIVE);
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Length of the current timed state, kept apart from cnt_q
  logic [SPC_CNT_W-1:0]   chk_len_q;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      chk_len_q <= '0;
    else if (state_q == SPC_RAMP || state_q == SPC_WAKE)
      chk_len_q <= chk_len_q + 1'b1;
    else
      chk_len_q <= '0;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_PIN_SYNC_DELAY: assert property (
    (state_q == SPC_ACTIVE && $fell(pin_s)) |-> $past(shutdown_pin_n, 2) == 1'b0)
    else $error("Shutdown acted before synchroniser");
  AST_IMM_SHUTDOWN: assert property (
    (state_q == SPC_ACTIVE && !pin_s && sel_q == SPC_SEL_HW_IMM)
      |=> state_q == SPC_HWSD)
    else $error("Immediate mode did not shut down");
  AST_SEQ_ENTER: assert property (
    (state_q == SPC_ACTIVE && !pin_s && sel_q != SPC_SEL_HW_IMM)
      |=> state_q == SPC_RAMP)
    else $error("Sequenced mode skipped sequence");
  AST_NORAMP_TIME: assert property (
    (state_q == SPC_RAMP && !ramp_latched_q)
      |-> (chk_len_q < SPC_CNT_W'(SPC_OFF_NORAMP_CYC - 2)
           ##1 state_q == SPC_RAMP)
       or (chk_len_q == SPC_CNT_W'(SPC_OFF_NORAMP_CYC - 2)
           ##1 state_q == SPC_PWRDN))
    else $error("Off time without ramp wrong");
  AST_HW_DEFAULTS: assert property (
    state_q == SPC_HWSD |=> ctrl.regs_to_default && !ctrl.i2c_enable
                            && sel_q == SPC_SEL_RESET)
    else $error("Hardware shutdown kept state");
  AST_SW_KEEP: assert property (
    (state_q == SPC_PWRDN && sel_q == SPC_SEL_SW_KEEP) |=>
      state_q == SPC_SWSD ##1 !ctrl.regs_to_default && ctrl.sw_shutdown)
    else $error("Software shutdown lost registers");
  AST_SW_I2C: assert property (
    (sel_q == SPC_SEL_SW_KEEP && state_q != SPC_WAKE) |=> ctrl.i2c_enable)
    else $error("Control port lost in mode 10");
  AST_WAKE_BOUND: assert property (
    state_q == SPC_WAKE |-> chk_len_q < SPC_CNT_W'(SPC_READY_CYC - 4))
    else $error("Not ready within 300 us");
  AST_POWER_DOWN: assert property (
    (state_q == SPC_HWSD || state_q == SPC_SWSD)
      |=> !ctrl.analog_on && !ctrl.amp_enable)
    else $error("Blocks still powered in shutdown");

  COV_HW_SEQ: cover property (state_q == SPC_PWRDN ##1 state_q == SPC_HWSD);
  COV_HW_IMM: cover property (state_q == SPC_ACTIVE ##1 state_q == SPC_HWSD);
  COV_SW_SD:  cover property (state_q == SPC_SWSD);
  COV_WAKE:   cover property (state_q == SPC_WAKE ##1 state_q == SPC_ACTIVE);
endmodule : spc_shutdown_ctrl
`default_nettype wire

/* spc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module spc_host_model
#(
  parameter int MIN_LOW = 4200
)
(
  input  wire logic clk_sys,
  input  wire logic sd_req,
  output var  logic shutdown_pin_n
);
  int low_cnt = 0;
  initial shutdown_pin_n = 1'b1;
  // ---------------------------------------------------------------
  // Pin driver
  // ---------------------------------------------------------------
  // Immediate mode is only requested once audio is idle
  // Pin stays low for the whole shutdown time without ramp
  always @(posedge clk_sys)
  begin
    if (sd_req || (!shutdown_pin_n && low_cnt < MIN_LOW))
    begin
      shutdown_pin_n <= #5 1'b0;
      low_cnt        <= low_cnt + 1;
    end
    else
    begin
      shutdown_pin_n <= #5 1'b1;
      low_cnt        <= 0;
    end
  end
endmodule : spc_host_model
`default_nettype wire

/* shutdown_pin_controller_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module shutdown_pin_controller_bench;
  import spc_pkg::*;
  logic                clk_sys, rst, sd_req, sel_wr_en, ramp_enable;
  logic                ad1, ad2, ready;
  logic [1:0]          sel_wr_data, sel, addr;
  spc_pkg::spc_ctrl_t  ctrl;
  wire                 pin_n;
  wire  [8:0]          obs;
  int                  n_errors = 0;
  int                  n_tests = 0;
  int                  cyc = 0;
  logic [31:0]         seed = 32'd56660;
  logic [1:0]          tbl [3] = '{2'h1, 2'h0, 2'h2};
  assign obs = {ctrl, ready};
  spc_host_model host (.clk_sys(clk_sys), .sd_req(sd_req),
    .shutdown_pin_n(pin_n));
  spc_shutdown_ctrl dut (.clk_sys(clk_sys), .rst(rst),
    .shutdown_pin_n(pin_n), .sel_wr_data(sel_wr_data),
    .sel_wr_en(sel_wr_en), .ramp_enable(ramp_enable),
    .address_select_pin_1(ad1), .address_select_pin_2(ad2),
    .shutdown_behaviour_select(sel), .ctrl(ctrl),
    .address_sampled(addr), .ready(ready));
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic check_bit(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected %s exp %b got %b", nm, e, g);
    end
  endtask : check_bit
  task automatic check_sel(input string nm, input logic [1:0] e,
                           input logic [1:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : check_sel
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #5;
  endtask : tick
  // Bounded wait for an observed bit to rise
  task automatic wait_bit(input string nm, input int idx, input int lim);
    int n;
    n = 0;
    while (obs[idx] !== 1'b1 && n < lim)
    begin
      tick(1);
      n++;
    end
    check_bit(nm, 1'b1, obs[idx]);
  endtask : wait_bit
  task automatic write_sel(input logic [1:0] v);
    sel_wr_data = v;
    sel_wr_en   = 1'b1;
    tick(1);
    sel_wr_en   = 1'b0;
    tick(1);
  endtask : write_sel
  // One full shutdown and wake-up in the given mode
  task automatic shut(input logic [1:0] m);
    logic [1:0] a;
    a = xs() % 4;
    write_sel(m);
    check_sel("select", m, sel);
    {ad2, ad1} = a;
    // Ramp would take 278000 cycles, so only immediate mode sets it
    ramp_enable = (m == SPC_SEL_HW_IMM) ? xs() % 2 : 1'b0;
    sd_req = 1'b1;
    @(negedge pin_n);
    tick(1);
    check_bit("i2c_enable", 1'b1, ctrl.i2c_enable);
    if (m == SPC_SEL_HW_IMM)
      wait_bit("hw_shutdown", 4, 6);
    else
    begin
      tick(SPC_OFF_NORAMP_CYC - 20);
      check_bit("still_on", 1'b0, ctrl.hw_shutdown | ctrl.sw_shutdown);
      wait_bit("off", m == SPC_SEL_SW_KEEP ? 3 : 4, 40);
    end
    check_bit("amp_enable", 1'b0, ctrl.amp_enable);
    check_bit("analog_on", 1'b0, ctrl.analog_on | ctrl.digital_on);
    check_bit("hw_off", m != SPC_SEL_SW_KEEP, ctrl.hw_shutdown);
    check_bit("defaults", m != SPC_SEL_SW_KEEP, ctrl.regs_to_default);
    check_bit("i2c_on", m == SPC_SEL_SW_KEEP, ctrl.i2c_enable);
    write_sel(2'h1);
    check_sel("sel_down", m == SPC_SEL_SW_KEEP ? 2'h1 : 2'h0, sel);
    sd_req = 1'b0;
    @(posedge pin_n);
    tick(4);
    {ad2, ad1} = ~a;
    wait_bit("ready", 0, SPC_READY_CYC - 4);
    check_sel("address", a, addr);
    tick(3);
  endtask : shut
  task automatic end_of_test();
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  // ---------------------------------------------------------------
  // Timeout, about 1.4 times the longest expected run
  // ---------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      n_errors++;
      end_of_test();
    end
  end
  initial
  begin
    {rst, sd_req, sel_wr_en, ramp_enable, ad1, ad2} = 6'h20;
    sel_wr_data = 2'h0;
    tick(5);
    rst = 1'b0;
    tick(1);
    check_sel("select_rst", SPC_SEL_RESET, sel);
    check_bit("ready_rst", 1'b1, ready);
    for (int i = 0; i < 6; i++)
      shut(i < 3 ? tbl[i] : tbl[xs() % 3]);
    // Ramped sequence is too long to finish, so cut it by reset
    write_sel(SPC_SEL_HW_SEQ);
    ramp_enable = 1'b1;
    sd_req      = 1'b1;
    @(negedge pin_n);
    tick(4);
    check_bit("ramp_down", 1'b1, ctrl.ramp_down);
    check_bit("amp_ramp", 1'b1, ctrl.amp_enable);
    check_bit("i2c_seq", 1'b0, ctrl.i2c_enable);
    rst    = 1'b1;
    sd_req = 1'b0;
    @(posedge pin_n);
    tick(5);
    rst = 1'b0;
    tick(1);
    check_bit("ramp_rst", 1'b0, ctrl.ramp_down);
    check_bit("ready_rst2", 1'b1, ready);
    check_sel("select_rst2", SPC_SEL_RESET, sel);
    end_of_test();
  end
endmodule : shutdown_pin_controller_bench
`default_nettype wire
